// ===== src/dpss_pkg.sv
// package of constants and types for the debug probe startup sequencer
package dpss_pkg;
  typedef enum logic [1:0] {
    DPSS_MODE_HALT = 2'b00,
    DPSS_MODE_DELAY = 2'b01,
    DPSS_MODE_RUN = 2'b10
  } dpss_mode_e;

  typedef enum logic [3:0] {
    DPSS_ST_IDLE = 4'b0000,
    DPSS_ST_RESET = 4'b0001,
    DPSS_ST_RELEASE = 4'b0010,
    DPSS_ST_WAIT = 4'b0011,
    DPSS_ST_HALT = 4'b0100,
    DPSS_ST_INIT = 4'b0101,
    DPSS_ST_INIT_WAIT = 4'b0110,
    DPSS_ST_RUNNING = 4'b0111,
    DPSS_ST_HALTED = 4'b1000
  } dpss_state_e;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
  } dpss_write_s;

  localparam int DPSS_INIT_DEPTH = 16;
  localparam int DPSS_IDX_W = 4;
  localparam int DPSS_CLK_HZ = 100_000_000;
  localparam int DPSS_RESET_HOLD_NS = 1000;
  localparam int DPSS_RESET_HOLD_CYC = (DPSS_RESET_HOLD_NS * (DPSS_CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int DPSS_MS_CYC = DPSS_CLK_HZ / 1000;
  localparam logic [14:0] DPSS_DELAY_MIN_MS = 15'd100;
  localparam logic [14:0] DPSS_DELAY_MAX_MS = 15'd32000;
  localparam logic [14:0] DPSS_DELAY_RST_MS = 15'd2000;
endpackage : dpss_pkg

// ===== src/dpss_sequencer.sv
// startup and attach sequencer driving target reset, halt and init-list writes
`timescale 1ns/1ps
`default_nettype none
module dpss_sequencer #(
  parameter int MS_CYC = dpss_pkg::DPSS_MS_CYC
) (
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  input wire dpss_pkg::dpss_mode_e startup_mode_in,
  input wire logic [14:0] startup_halt_delay_in,
  input wire logic attach_halt_in,
  input wire logic attach_in,
  input wire logic stop_req_in,
  input wire logic init_load_in,
  input wire logic [dpss_pkg::DPSS_IDX_W-1:0] init_load_idx_in,
  input wire dpss_pkg::dpss_write_s init_load_entry_in,
  input wire logic [dpss_pkg::DPSS_IDX_W:0] init_count_in,
  input wire logic halt_ack_in,
  input wire logic write_done_in,
  output logic target_reset_n_out,
  output logic halt_req_out,
  output logic write_valid_out,
  output dpss_pkg::dpss_write_s write_out,
  output logic halted_out,
  output logic busy_out,
  output logic delay_bad_out
);
  import dpss_pkg::*;

  logic rst_s1_q;
  logic rst_n_q;
  dpss_state_e state_q;
  dpss_mode_e mode_q;
  logic attach_seq_q;
  logic [15:0] cyc_q;
  // one millisecond at the full clock rate needs more than 16 bits
  logic [16:0] tick_q;
  logic [14:0] ms_q;
  logic [14:0] delay_q;
  logic [DPSS_IDX_W:0] idx_q;
  dpss_write_s init_mem [DPSS_INIT_DEPTH];
  logic delay_ok;

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rst_s1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q <= rst_s1_q;
    end
  end

  // init list storage has no reset: it is loaded by software before use
  always_ff @(posedge core_clk_in) begin
    if (init_load_in) begin
      init_mem[init_load_idx_in] <= init_load_entry_in;
    end
  end

  // out-of-range delays are refused and the last accepted value kept
  assign delay_ok = (startup_halt_delay_in >= DPSS_DELAY_MIN_MS) &&
                    (startup_halt_delay_in <= DPSS_DELAY_MAX_MS);

  always_ff @(posedge core_clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      delay_q <= DPSS_DELAY_RST_MS;
      delay_bad_out <= 1'b0;
    end else begin
      delay_bad_out <= !delay_ok;
      if (delay_ok) begin
        delay_q <= startup_halt_delay_in;
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      state_q <= DPSS_ST_IDLE;
      mode_q <= DPSS_MODE_HALT;
      attach_seq_q <= 1'b0;
      cyc_q <= 16'h0000;
      tick_q <= 17'h00000;
      ms_q <= 15'h0000;
      idx_q <= '0;
      target_reset_n_out <= 1'b1;
      halt_req_out <= 1'b0;
      write_valid_out <= 1'b0;
      write_out <= '0;
      halted_out <= 1'b0;
      busy_out <= 1'b1;
    end else begin
      case (state_q)
        DPSS_ST_IDLE: begin
          // unknown encodings fall back to the standard mode
          mode_q <= (startup_mode_in == DPSS_MODE_DELAY || startup_mode_in == DPSS_MODE_RUN) ?
                    startup_mode_in : DPSS_MODE_HALT;
          attach_seq_q <= 1'b0;
          target_reset_n_out <= 1'b0;
          cyc_q <= 16'h0000;
          busy_out <= 1'b1;
          state_q <= DPSS_ST_RESET;
        end
        DPSS_ST_RESET: begin
          // hold reset for the fixed minimum before release
          if (cyc_q == 16'(DPSS_RESET_HOLD_CYC - 1)) begin
            cyc_q <= 16'h0000;
            state_q <= DPSS_ST_RELEASE;
            if (mode_q == DPSS_MODE_HALT) begin
              halt_req_out <= 1'b1;
            end
          end else begin
            cyc_q <= cyc_q + 16'h0001;
          end
        end
        DPSS_ST_RELEASE: begin
          target_reset_n_out <= 1'b1;
          ms_q <= 15'h0000;
          cyc_q <= 16'h0000;
          tick_q <= 17'h00000;
          if (mode_q == DPSS_MODE_HALT) begin
            state_q <= DPSS_ST_HALT;
          end else if (mode_q == DPSS_MODE_DELAY) begin
            state_q <= DPSS_ST_WAIT;
          end else begin
            state_q <= DPSS_ST_RUNNING;
            busy_out <= 1'b0;
          end
        end
        DPSS_ST_WAIT: begin
          // target boot code is expected to idle in a loop meanwhile
          if (tick_q == 17'(MS_CYC - 1)) begin
            tick_q <= 17'h00000;
            // a delay lowered mid-wait halts at the end of the current millisecond instead of wrapping the count
            if (ms_q >= delay_q - 15'h0001) begin
              halt_req_out <= 1'b1;
              state_q <= DPSS_ST_HALT;
            end else begin
              ms_q <= ms_q + 15'h0001;
            end
          end else begin
            tick_q <= tick_q + 17'h00001;
          end
        end
        DPSS_ST_HALT: begin
          if (halt_ack_in) begin
            halt_req_out <= 1'b0;
            halted_out <= 1'b1;
            idx_q <= '0;
            // attach and free-run halts skip the init list
            if (mode_q == DPSS_MODE_RUN || attach_seq_q) begin
              state_q <= DPSS_ST_HALTED;
              busy_out <= 1'b0;
            end else begin
              state_q <= DPSS_ST_INIT;
            end
          end
        end
        DPSS_ST_INIT: begin
          if (idx_q >= init_count_in || idx_q == (DPSS_IDX_W+1)'(DPSS_INIT_DEPTH)) begin
            state_q <= DPSS_ST_HALTED;
            busy_out <= 1'b0;
          end else begin
            write_out <= init_mem[idx_q[DPSS_IDX_W-1:0]];
            write_valid_out <= 1'b1;
            state_q <= DPSS_ST_INIT_WAIT;
          end
        end
        DPSS_ST_INIT_WAIT: begin
          if (write_done_in) begin
            write_valid_out <= 1'b0;
            idx_q <= idx_q + (DPSS_IDX_W+1)'(1);
            state_q <= DPSS_ST_INIT;
          end
        end
        DPSS_ST_RUNNING, DPSS_ST_HALTED: begin
          if (attach_in && !attach_halt_in) begin
            target_reset_n_out <= 1'b0;
            attach_seq_q <= 1'b0;
            halted_out <= 1'b0;
            busy_out <= 1'b1;
            cyc_q <= 16'h0000;
            state_q <= DPSS_ST_RESET;
          end else if ((attach_in || stop_req_in) && state_q == DPSS_ST_RUNNING) begin
            halt_req_out <= 1'b1;
            attach_seq_q <= 1'b1;
            busy_out <= 1'b1;
            state_q <= DPSS_ST_HALT;
          end
        end
        default: begin
          state_q <= DPSS_ST_IDLE;
        end
      endcase
    end
  end

  logic [15:0] rst_low_q;
  always_ff @(posedge core_clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rst_low_q <= 16'h0000;
    end else begin
      rst_low_q <= target_reset_n_out ? 16'h0000 : rst_low_q + 16'h0001;
    end
  end

  property p_reset_hold;
    @(posedge core_clk_in) disable iff (!rst_n_q)
      $rose(target_reset_n_out) |-> $past(rst_low_q) >= 16'(DPSS_RESET_HOLD_CYC);
  endproperty
  a_reset_hold: assert property (p_reset_hold) else $error("reset released early");

  property p_halt_in_reset;
    @(posedge core_clk_in) disable iff (!rst_n_q)
      ($rose(target_reset_n_out) && mode_q == DPSS_MODE_HALT && !attach_seq_q) |-> halt_req_out;
  endproperty
  a_halt_in_reset: assert property (p_halt_in_reset) else $error("no halt at release");

  property p_run_no_halt;
    @(posedge core_clk_in) disable iff (!rst_n_q)
      (state_q == DPSS_ST_RUNNING && !attach_in && !stop_req_in) |=> !halt_req_out;
  endproperty
  a_run_no_halt: assert property (p_run_no_halt) else $error("free run halted");

  property p_stop_halts;
    @(posedge core_clk_in) disable iff (!rst_n_q)
      (state_q == DPSS_ST_RUNNING && stop_req_in && !attach_in) |=> halt_req_out && target_reset_n_out;
  endproperty
  a_stop_halts: assert property (p_stop_halts) else $error("stop not honoured");

  property p_attach_reset;
    @(posedge core_clk_in) disable iff (!rst_n_q)
      ((state_q == DPSS_ST_RUNNING || state_q == DPSS_ST_HALTED) && attach_in && !attach_halt_in)
      |=> !target_reset_n_out;
  endproperty
  a_attach_reset: assert property (p_attach_reset) else $error("attach without reset");

  property p_attach_halt;
    @(posedge core_clk_in) disable iff (!rst_n_q)
      (state_q == DPSS_ST_RUNNING && attach_in && attach_halt_in)
      |=> halt_req_out && target_reset_n_out;
  endproperty
  a_attach_halt: assert property (p_attach_halt) else $error("attach halt wrong");

  property p_delay_keep;
    @(posedge core_clk_in) disable iff (!rst_n_q)
      !delay_ok |=> delay_q == $past(delay_q) && delay_bad_out;
  endproperty
  a_delay_keep: assert property (p_delay_keep) else $error("bad delay taken");

  property p_write_hold;
    @(posedge core_clk_in) disable iff (!rst_n_q)
      (write_valid_out && !write_done_in) |=> write_valid_out && $stable(write_out);
  endproperty
  a_write_hold: assert property (p_write_hold) else $error("write dropped");

  property p_delay_no_early;
    @(posedge core_clk_in) disable iff (!rst_n_q)
      (state_q == DPSS_ST_WAIT && ms_q < delay_q - 15'h0001) |=> !halt_req_out;
  endproperty
  a_delay_no_early: assert property (p_delay_no_early) else $error("early halt");

  c_init_write: cover property (@(posedge core_clk_in) write_valid_out && write_done_in);
  c_delay_halt: cover property (@(posedge core_clk_in) state_q == DPSS_ST_WAIT ##1 halt_req_out);
  c_attach_halt: cover property (@(posedge core_clk_in)
    state_q == DPSS_ST_RUNNING && attach_in && attach_halt_in);
endmodule : dpss_sequencer
`default_nettype wire

// ===== verif/dpss_target_model.sv
// behavioural target processor: answers halt and write requests after short waits
`timescale 1ns/1ps
`default_nettype none
module dpss_target_model (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic halt_req_in,
  input wire logic write_valid_in,
  input wire dpss_pkg::dpss_write_s write_in,
  output logic halt_ack_out,
  output logic write_done_out,
  output int wr_cnt,
  output int rst_cyc,
  output int run_cyc,
  output int rst_falls,
  output dpss_pkg::dpss_write_s last_wr
);
  import dpss_pkg::*;
  int hc;
  int wc;
  logic rlow;
  logic stopped;
  // boot code loops forever; only a halt request seen out of reset stops it
  always @(posedge clk_in) begin
    halt_ack_out <= halt_req_in && rst_n_in && hc == 2;
    hc <= (halt_req_in && rst_n_in && !halt_ack_out) ? hc + 1 : 0;
    write_done_out <= write_valid_in && wc == 1;
    wc <= (write_valid_in && !write_done_out) ? wc + 1 : 0;
    if (write_valid_in && write_done_out) begin
      wr_cnt <= wr_cnt + 1;
      last_wr <= write_in;
    end
    rlow <= !rst_n_in;
    if (!rst_n_in) rst_cyc <= rlow ? rst_cyc + 1 : 1;
    if (!rst_n_in && !rlow) rst_falls <= rst_falls + 1;
    stopped <= rst_n_in && (stopped || halt_req_in);
    if (!rst_n_in) run_cyc <= 0;
    else if (!stopped && !halt_req_in) run_cyc <= run_cyc + 1;
  end
endmodule : dpss_target_model
`default_nettype wire

// ===== verif/debug_probe_startup_sequencer_tb_top.sv
// self-checking bench for the startup sequencer
`timescale 1ns/1ps
`default_nettype none
module debug_probe_startup_sequencer_tb_top;
  import dpss_pkg::*;
  localparam int MS = 10;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  dpss_mode_e mode = DPSS_MODE_HALT;
  logic [14:0] dly = 15'd100;
  logic att_halt = 1'b0;
  logic attach = 1'b0;
  logic stop_req = 1'b0;
  logic ld = 1'b0;
  logic [3:0] ld_idx = 4'h0;
  dpss_write_s ld_ent = '0;
  logic [4:0] cnt = 5'h02;
  logic ack, done, trst_n, hreq, wv, halted, busy, dbad;
  dpss_write_s wr, last_wr;
  int wr_cnt, rst_cyc, run_cyc, rst_falls, w0, f0;
  int failures = 0;
  int check_count = 0;
  always #5 clk = ~clk;
  dpss_sequencer #(.MS_CYC(MS)) i_dut (.core_clk_in(clk), .reset_n_in(rst_n),
    .startup_mode_in(mode), .startup_halt_delay_in(dly), .attach_halt_in(att_halt),
    .attach_in(attach), .stop_req_in(stop_req), .init_load_in(ld),
    .init_load_idx_in(ld_idx), .init_load_entry_in(ld_ent), .init_count_in(cnt),
    .halt_ack_in(ack), .write_done_in(done), .target_reset_n_out(trst_n),
    .halt_req_out(hreq), .write_valid_out(wv), .write_out(wr), .halted_out(halted),
    .busy_out(busy), .delay_bad_out(dbad));
  dpss_target_model i_tgt (.clk_in(clk), .rst_n_in(trst_n), .halt_req_in(hreq),
    .write_valid_in(wv), .write_in(wr), .halt_ack_out(ack), .write_done_out(done),
    .wr_cnt(wr_cnt), .rst_cyc(rst_cyc), .run_cyc(run_cyc), .rst_falls(rst_falls),
    .last_wr(last_wr));
  task chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  function automatic dpss_write_s ent(input int i);
    return {32'h2000_0000 + 32'(i) * 32'h4, 32'hc0de_0000 + 32'(i)};
  endfunction : ent
  task tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  // list storage has no reset and keeps its contents, yet it is reloaded each time
  task restart(input dpss_mode_e m);
    mode <= m;
    rst_n <= 1'b0;
    tick(4);
    rst_n <= 1'b1;
    tick(3);
    for (int i = 0; i < 2; i++) begin
      ld <= 1'b1;
      ld_idx <= 4'(i);
      ld_ent <= ent(i);
      tick(1);
    end
    ld <= 1'b0;
  endtask : restart
  task pulse(input bit st);
    if (st) stop_req <= 1'b1;
    else attach <= 1'b1;
    tick(1);
    stop_req <= 1'b0;
    attach <= 1'b0;
    tick(3);
  endtask : pulse
  task settle(input bit need_h, input int n);
    int k;
    k = 0;
    while ((busy !== 1'b0 || (need_h && halted !== 1'b1)) && k < n) begin
      tick(1);
      k++;
    end
    if (k >= n) begin
      failures++;
      $display("[ERR] sequence did not finish");
    end
  endtask : settle
  task conclude;
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : conclude
  initial begin
    #300us;
    failures++;
    $display("[ERR] watchdog expired");
    conclude();
  end
  initial begin
    restart(DPSS_MODE_HALT);
    w0 = wr_cnt;
    settle(1, 500);
    chk("reset_hold", 64'(rst_cyc >= DPSS_RESET_HOLD_CYC && rst_cyc <= DPSS_RESET_HOLD_CYC + 1), 64'h1);
    chk("halt_at_release", 64'(run_cyc), 64'h0);
    chk("init_writes", 64'(wr_cnt - w0), 64'h2);
    chk("last_write", last_wr, ent(1));
    $display("test default startup done");
    w0 = wr_cnt;
    f0 = rst_falls;
    pulse(1'b0);
    settle(1, 500);
    chk("attach_reset", 64'(rst_falls - f0), 64'h1);
    chk("attach_init", 64'(wr_cnt - w0), 64'h2);
    $display("test attach reset done");
    dly <= 15'd99;
    tick(3);
    chk("delay_low", dbad, 64'h1);
    dly <= 15'd32001;
    tick(3);
    chk("delay_high", dbad, 64'h1);
    dly <= 15'd100;
    tick(3);
    chk("delay_ok", dbad, 64'h0);
    $display("test delay range done");
    restart(DPSS_MODE_DELAY);
    w0 = wr_cnt;
    settle(1, 2000);
    chk("delay_run", 64'(run_cyc >= 100 * MS && run_cyc <= 100 * MS + 2), 64'h1);
    chk("delay_init", 64'(wr_cnt - w0), 64'h2);
    $display("test delayed halt done");
    restart(DPSS_MODE_RUN);
    settle(0, 500);
    tick(50);
    chk("run_free", {hreq, halted}, 64'h0);
    w0 = wr_cnt;
    pulse(1'b1);
    settle(1, 100);
    chk("stop_halts", halted, 64'h1);
    f0 = rst_falls;
    pulse(1'b0);
    settle(0, 500);
    tick(20);
    chk("rerun_reset", 64'(rst_falls - f0), 64'h1);
    chk("rerun_free", halted, 64'h0);
    att_halt <= 1'b1;
    f0 = rst_falls;
    pulse(1'b0);
    settle(1, 100);
    chk("attach_no_reset", 64'(rst_falls - f0), 64'h0);
    chk("attach_halted", halted, 64'h1);
    chk("no_init_writes", 64'(wr_cnt - w0), 64'h0);
    $display("test free run done");
    restart(dpss_mode_e'(2'b11));
    w0 = wr_cnt;
    settle(1, 500);
    chk("odd_mode_halt", 64'(run_cyc), 64'h0);
    chk("odd_mode_init", 64'(wr_cnt - w0), 64'h2);
    $display("test mode fallback done");
    conclude();
  end
endmodule : debug_probe_startup_sequencer_tb_top
`default_nettype wire
